// ### verilog/rtcc_pkg.sv
// Constants and types of the RTC control and event flag block
package rtcc_pkg;
  // ==========================================================
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_SEC = 8'h00;
  localparam logic [7:0] OFF_ALM_SEC = 8'h01;
  localparam logic [7:0] OFF_MIN = 8'h02;
  localparam logic [7:0] OFF_ALM_MIN = 8'h03;
  localparam logic [7:0] OFF_HOUR = 8'h04;
  localparam logic [7:0] OFF_ALM_HOUR = 8'h05;
  localparam logic [7:0] OFF_DOW = 8'h06;
  localparam logic [7:0] OFF_DATE = 8'h07;
  localparam logic [7:0] OFF_MON = 8'h08;
  localparam logic [7:0] OFF_YEAR = 8'h09;
  localparam logic [7:0] OFF_RATE = 8'h0A;
  localparam logic [7:0] OFF_CONFIG = 8'h0B;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  // ==========================================================
  // Values after reset
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  localparam logic [3:0] RATE_RST = 4'h0;
  localparam logic [2:0] DOW_RST = 3'h1;
  localparam logic [4:0] DATE_RST = 5'h01;
  localparam logic [3:0] MON_RST = 4'h1;
  // ==========================================================
  // Calendar limits and conversion
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam logic [4:0] NOON = 5'h0C;
  localparam logic [2:0] DOW_LAST = 3'h7;
  localparam logic [3:0] MON_LAST = 4'hC;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [6:0] YEAR_LAST = 7'h63;
  localparam logic [6:0] BCD_BASE = 7'h0A;
  localparam logic [4:0] DAYS_28 = 5'h1C;
  localparam logic [4:0] DAYS_29 = 5'h1D;
  localparam logic [4:0] DAYS_30 = 5'h1E;
  localparam logic [4:0] DAYS_31 = 5'h1F;
  // ==========================================================
  // Daylight saving points
  localparam logic [2:0] DST_SUNDAY = 3'h1;
  localparam logic [3:0] DST_SPRING_MON = 4'h4;
  localparam logic [3:0] DST_FALL_MON = 4'hA;
  localparam logic [4:0] DST_FIRST_WEEK_END = 5'h07;
  localparam logic [4:0] DST_LAST_WEEK_START = 5'h19;
  localparam logic [4:0] DST_HOUR = 5'h01;
  localparam logic [4:0] DST_SPRING_HOUR = 5'h03;
  // ==========================================================
  // Timing: one crystal period of the 32768 Hz time base
  localparam int CLK_PERIOD_NS = 25;
  localparam int XTAL_PERIOD_NS = 30518;
  localparam int TICK_CYCLES = XTAL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_MAX = 4096;
  localparam int DIV_W = 15;
  localparam logic [3:0] TAP_LOW_CODES = 4'h3;
  localparam logic [3:0] TAP_LOW_ADD = 4'h5;
  localparam logic [3:0] TAP_HIGH_SUB = 4'h2;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_INC = 2'b01,
    ST_CHECK = 2'b10
  } rtcc_state_type;
  typedef struct packed {
    logic update_inhibit;
    logic periodic_irq_enable;
    logic alarm_irq_enable;
    logic update_done_irq_enable;
    logic square_wave_enable;
    logic data_mode;
    logic hour_format;
    logic daylight_saving_enable;
  } rtcc_cfg_type;
  typedef struct packed {
    logic periodic_flag;
    logic alarm_flag;
    logic update_done_flag;
  } rtcc_flags_type;
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rtcc_hms_type;
endpackage

// ### verilog/rtcc_core.sv
// RTC timekeeping, configuration register and event flag register
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module rtcc_core #(
  parameter int TICK_CYCLES = rtcc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Resume-well reset pin, asynchronous
  input wire logic resume_well_reset_n_in,
  // Register port
  input wire logic [rtcc_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [rtcc_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [rtcc_pkg::DATA_W-1:0] reg_rdata_out,
  // Interrupt
  output logic clock_interrupt_n_out
);
  import rtcc_pkg::*;

  // ==========================================================
  // Parameter check
  generate
    if (TICK_CYCLES < 1 || TICK_CYCLES > TICK_MAX) begin : g_bad
      $error("TICK_CYCLES out of range");
    end
  endgenerate

  // ==========================================================
  // Conversion functions
  // Binary value to register byte in binary or BCD
  function automatic logic [7:0] enc(input logic [6:0] v,
                                     input logic bin);
    logic [6:0] tens;
    logic [6:0] ones;
    tens = v / BCD_BASE;
    ones = 7'(v - 7'(tens * BCD_BASE));
    enc = bin ? {1'b0, v} : {tens[3:0], ones[3:0]};
  endfunction

  // Register byte in binary or BCD to binary value
  function automatic logic [6:0] dec(input logic [7:0] b,
                                     input logic bin);
    dec = bin ? b[6:0]
              : 7'(7'(b[7:4]) * BCD_BASE + 7'(b[3:0]));
  endfunction

  // Internal 24 hour value to hour byte
  function automatic logic [7:0] hr_rd(input logic [4:0] h,
                                       input rtcc_cfg_type c);
    logic [4:0] h12;
    logic [7:0] b;
    h12 = (h == 5'h00) ? NOON : ((h > NOON) ? 5'(h - NOON) : h);
    b = enc({2'b00, c.hour_format ? h : h12}, c.data_mode);
    hr_rd = c.hour_format ? b : {(h >= NOON), b[6:0]};
  endfunction

  // Hour byte to internal 24 hour value
  function automatic logic [4:0] hr_wr(input logic [7:0] b,
                                       input rtcc_cfg_type c);
    logic [4:0] raw;
    raw = 5'(dec({1'b0, b[6:0]}, c.data_mode));
    if (c.hour_format) begin
      hr_wr = raw;
    end else if (raw == NOON) begin
      hr_wr = b[7] ? NOON : 5'h00;
    end else begin
      hr_wr = b[7] ? 5'(raw + NOON) : raw;
    end
  endfunction

  // Days of a month
  function automatic logic [4:0] dim(input logic [3:0] m,
                                     input logic leap);
    case (m)
      MON_FEB: dim = leap ? DAYS_29 : DAYS_28;
      4'h4, 4'h6, 4'h9, 4'hB: dim = DAYS_30;
      default: dim = DAYS_31;
    endcase
  endfunction

  // Divider bit that a rate code taps
  function automatic logic [3:0] tap_idx(input logic [3:0] rs);
    tap_idx = (rs < TAP_LOW_CODES) ? 4'(rs + TAP_LOW_ADD)
                                   : 4'(rs - TAP_HIGH_SUB);
  endfunction

  // ==========================================================
  // State
  rtcc_cfg_type cfg_q, cfg_d;
  rtcc_flags_type flags_q, flags_d;
  rtcc_hms_type time_q, time_d, alm_q, alm_d, nt;
  rtcc_state_type state_q, state_d;
  logic [2:0] dow_q, dow_d, nd;
  logic [4:0] date_q, date_d, ndate;
  logic [3:0] mon_q, mon_d, nmon;
  logic [6:0] year_q, year_d, nyear;
  logic [3:0] rate_q, rate_d;
  logic [11:0] pre_q, pre_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [2:0] rsm_q;
  logic rsm_act_q;
  logic fall_done_q, fall_done_d, fall_set;
  logic [7:0] rdata_q, rdata_d, rd_mux;
  logic irq_n_q;

  // ==========================================================
  // Register port decode
  wire wr_cfg = reg_wr_in && reg_addr_in == OFF_CONFIG;
  wire rd_flags = reg_rd_in && reg_addr_in == OFF_FLAGS;
  wire wr_sec = reg_wr_in && reg_addr_in == OFF_SEC;
  wire wr_min = reg_wr_in && reg_addr_in == OFF_MIN;
  wire wr_hour = reg_wr_in && reg_addr_in == OFF_HOUR;
  wire wr_asec = reg_wr_in && reg_addr_in == OFF_ALM_SEC;
  wire wr_amin = reg_wr_in && reg_addr_in == OFF_ALM_MIN;
  wire wr_ahour = reg_wr_in && reg_addr_in == OFF_ALM_HOUR;
  wire wr_dow = reg_wr_in && reg_addr_in == OFF_DOW;
  wire wr_date = reg_wr_in && reg_addr_in == OFF_DATE;
  wire wr_mon = reg_wr_in && reg_addr_in == OFF_MON;
  wire wr_year = reg_wr_in && reg_addr_in == OFF_YEAR;
  wire wr_rate = reg_wr_in && reg_addr_in == OFF_RATE;
  // Write data in the current data mode
  wire [6:0] wval = dec(reg_wdata_in, cfg_q.data_mode);
  wire [4:0] whour = hr_wr(reg_wdata_in, cfg_q);

  // ==========================================================
  // Resume-well reset pin synchroniser, asserted when low
  wire rsm_act = rsm_act_q;

  // ==========================================================
  // Time base: crystal tick prescaler and 15 stage divider
  wire xtick = pre_q == 12'(TICK_CYCLES - 1);
  assign pre_d = xtick ? 12'h000 : 12'(pre_q + 12'h001);
  assign div_d = xtick ? DIV_W'(div_q + 1'b1) : div_q;
  wire sec_tick = xtick && (&div_q);
  // Periodic tap rising edge; code zero taps nothing
  wire [3:0] tap = tap_idx(rate_q);
  wire pf_set = xtick && rate_q != 4'h0
                && div_d[tap] && !div_q[tap];

  // ==========================================================
  // Update cycle sequencing
  wire upd = state_q == ST_INC && !cfg_q.update_inhibit;
  wire done = state_q == ST_CHECK && !cfg_q.update_inhibit;
  wire alm_hit = alm_q == time_q;
  wire af_set = done && alm_hit;
  wire uf_set = done;
  // Idle waits for the second; inhibit aborts the cycle
  always_comb begin
    case (state_q)
      ST_IDLE:
        state_d = (sec_tick && !cfg_q.update_inhibit) ? ST_INC
                                                       : ST_IDLE;
      ST_INC:
        state_d = cfg_q.update_inhibit ? ST_IDLE : ST_CHECK;
      ST_CHECK:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Daylight saving conditions
  wire at_159 = time_q.hour == DST_HOUR && time_q.min == SEC_LAST
                && time_q.sec == SEC_LAST;
  wire spring = cfg_q.daylight_saving_enable
                && mon_q == DST_SPRING_MON && dow_q == DST_SUNDAY
                && date_q <= DST_FIRST_WEEK_END && at_159;
  wire fall = cfg_q.daylight_saving_enable
              && mon_q == DST_FALL_MON && dow_q == DST_SUNDAY
              && date_q >= DST_LAST_WEEK_START && at_159
              && !fall_done_q;
  wire leap = year_q[1:0] == 2'b00;

  // Next time and date of one update
  always_comb begin
    nt = time_q;
    nd = dow_q;
    ndate = date_q;
    nmon = mon_q;
    nyear = year_q;
    fall_set = 1'b0;
    if (spring) begin
      nt.hour = DST_SPRING_HOUR;
      nt.min = 6'h00;
      nt.sec = 6'h00;
    end else if (fall) begin
      nt.min = 6'h00;
      nt.sec = 6'h00;
      fall_set = 1'b1;
    end else if (time_q.sec != SEC_LAST) begin
      nt.sec = 6'(time_q.sec + 6'h01);
    end else begin
      nt.sec = 6'h00;
      if (time_q.min != SEC_LAST) begin
        nt.min = 6'(time_q.min + 6'h01);
      end else begin
        nt.min = 6'h00;
        if (time_q.hour != HOUR_LAST) begin
          nt.hour = 5'(time_q.hour + 5'h01);
        end else begin
          nt.hour = 5'h00;
          nd = (dow_q == DOW_LAST) ? 3'h1 : 3'(dow_q + 3'h1);
          if (date_q != dim(mon_q, leap)) begin
            ndate = 5'(date_q + 5'h01);
          end else begin
            ndate = 5'h01;
            if (mon_q != MON_LAST) begin
              nmon = 4'(mon_q + 4'h1);
            end else begin
              nmon = 4'h1;
              nyear = (year_q == YEAR_LAST) ? 7'h00
                                            : 7'(year_q + 7'h01);
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // Time, alarm and calendar next values; software write wins
  assign time_d.sec = wr_sec ? 6'(wval) : (upd ? nt.sec : time_q.sec);
  assign time_d.min = wr_min ? 6'(wval) : (upd ? nt.min : time_q.min);
  assign time_d.hour = wr_hour ? whour
                               : (upd ? nt.hour : time_q.hour);
  assign alm_d.sec = wr_asec ? 6'(wval) : alm_q.sec;
  assign alm_d.min = wr_amin ? 6'(wval) : alm_q.min;
  assign alm_d.hour = wr_ahour ? whour : alm_q.hour;
  assign dow_d = wr_dow ? 3'(wval) : (upd ? nd : dow_q);
  assign date_d = wr_date ? 5'(wval) : (upd ? ndate : date_q);
  assign mon_d = wr_mon ? 4'(wval) : (upd ? nmon : mon_q);
  assign year_d = wr_year ? wval : (upd ? nyear : year_q);
  assign rate_d = wr_rate ? reg_wdata_in[3:0] : rate_q;
  // Autumn adjustment happens once; a new day re-arms it
  assign fall_done_d = (upd && fall_set) ? 1'b1
                     : ((upd && ndate != date_q) ? 1'b0 : fall_done_q);

  // ==========================================================
  // Configuration register; resume reset clears the interrupt and square wave enables
  always_comb begin
    cfg_d = wr_cfg ? rtcc_cfg_type'(reg_wdata_in) : cfg_q;
    if (rsm_act) begin
      cfg_d.periodic_irq_enable = 1'b0;
      cfg_d.alarm_irq_enable = 1'b0;
      cfg_d.update_done_irq_enable = 1'b0;
      cfg_d.square_wave_enable = 1'b0;
    end
  end

  // ==========================================================
  // Event flags: a new event wins over the read clear
  wire clr = rd_flags;
  assign flags_d.periodic_flag = !rsm_act
    && (pf_set || (flags_q.periodic_flag && !clr));
  assign flags_d.alarm_flag = !rsm_act
    && (af_set || (flags_q.alarm_flag && !clr));
  assign flags_d.update_done_flag = !rsm_act
    && (uf_set || (flags_q.update_done_flag && !clr));

  // Combined request; the update alias equals its enable
  function automatic logic interrupt_request_flag(input rtcc_flags_type f,
                                input rtcc_cfg_type c);
    logic update_done_enable_alias;
    update_done_enable_alias = c.update_done_irq_enable;
    interrupt_request_flag = (f.periodic_flag && c.periodic_irq_enable)
         || (f.alarm_flag && c.alarm_irq_enable)
         || (f.update_done_flag && update_done_enable_alias);
  endfunction
  wire irq_now = interrupt_request_flag(flags_q, cfg_q);

  // ==========================================================
  // Read data multiplexer; unmapped addresses read zero
  always_comb begin
    case (reg_addr_in)
      OFF_SEC: rd_mux = enc({1'b0, time_q.sec}, cfg_q.data_mode);
      OFF_MIN: rd_mux = enc({1'b0, time_q.min}, cfg_q.data_mode);
      OFF_HOUR: rd_mux = hr_rd(time_q.hour, cfg_q);
      OFF_ALM_SEC: rd_mux = enc({1'b0, alm_q.sec}, cfg_q.data_mode);
      OFF_ALM_MIN: rd_mux = enc({1'b0, alm_q.min}, cfg_q.data_mode);
      OFF_ALM_HOUR: rd_mux = hr_rd(alm_q.hour, cfg_q);
      OFF_DOW: rd_mux = enc({4'h0, dow_q}, cfg_q.data_mode);
      OFF_DATE: rd_mux = enc({2'b00, date_q}, cfg_q.data_mode);
      OFF_MON: rd_mux = enc({3'b000, mon_q}, cfg_q.data_mode);
      OFF_YEAR: rd_mux = enc(year_q, cfg_q.data_mode);
      OFF_RATE: rd_mux = {4'h0, rate_q};
      OFF_CONFIG: rd_mux = cfg_q;
      OFF_FLAGS: rd_mux = {irq_now, flags_q, 4'h0};
      default: rd_mux = 8'h00;
    endcase
  end
  assign rdata_d = reg_rd_in ? rd_mux : 8'h00;

  // ==========================================================
  // Resume reset pin: three stages, acts when last two agree
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsm_q <= 3'h7;
      rsm_act_q <= 1'b0;
    end else begin
      rsm_q <= {rsm_q[1:0], resume_well_reset_n_in};
      if (rsm_q[2] == rsm_q[1]) begin
        rsm_act_q <= !rsm_q[1];
      end
    end
  end

  // Control and flag registers
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_q <= rtcc_cfg_type'(CONFIG_RST);
      flags_q <= rtcc_flags_type'(FLAGS_RST);
      rate_q <= RATE_RST;
      state_q <= ST_IDLE;
      rdata_q <= 8'h00;
      irq_n_q <= 1'b1;
    end else begin
      cfg_q <= cfg_d;
      flags_q <= flags_d;
      rate_q <= rate_d;
      state_q <= state_d;
      rdata_q <= rdata_d;
      irq_n_q <= !interrupt_request_flag(flags_d, cfg_d);
    end
  end

  // Time base and timekeeping registers
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pre_q <= 12'h000;
      div_q <= '0;
      time_q <= '0;
      alm_q <= '0;
      dow_q <= DOW_RST;
      date_q <= DATE_RST;
      mon_q <= MON_RST;
      year_q <= 7'h00;
      fall_done_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      div_q <= div_d;
      time_q <= time_d;
      alm_q <= alm_d;
      dow_q <= dow_d;
      date_q <= date_d;
      mon_q <= mon_d;
      year_q <= year_d;
      fall_done_q <= fall_done_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign clock_interrupt_n_out = irq_n_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_flag_read;
    rd_flags && !rsm_act && !pf_set && !af_set && !uf_set;
  endsequence
  sequence s_update_done;
    state_q == ST_CHECK && !cfg_q.update_inhibit && !rsm_act;
  endsequence
  sequence s_spring_step;
    upd && spring && !reg_wr_in;
  endsequence

  inhibit_abort_a: assert property (
    state_q == ST_INC && cfg_q.update_inhibit && !reg_wr_in
    |=> state_q == ST_IDLE && $stable(time_q)
        && !$rose(flags_q.update_done_flag))
    else $error("update not aborted by inhibit");
  resume_clear_a: assert property (
    rsm_act |=> !cfg_q.periodic_irq_enable && !cfg_q.alarm_irq_enable
      && !cfg_q.update_done_irq_enable && !cfg_q.square_wave_enable)
    else $error("resume reset left an enable set");
  resume_keep_a: assert property (
    rsm_act && !wr_cfg |=> cfg_q.update_inhibit
      == $past(cfg_q.update_inhibit) && $stable(cfg_q.data_mode)
      && $stable(cfg_q.hour_format)
      && $stable(cfg_q.daylight_saving_enable))
    else $error("resume reset changed a kept bit");
  irq_pin_a: assert property (
    flags_q.periodic_flag && cfg_q.periodic_irq_enable
    |-> !clock_interrupt_n_out)
    else $error("interrupt not asserted for periodic flag");
  flag_clear_a: assert property (
    s_flag_read |=> flags_q == 3'h0)
    else $error("flags not cleared by read");
  read_before_a: assert property (
    rd_flags |=> reg_rdata_out[6:4] == $past(flags_q)
      && reg_rdata_out[3:0] == 4'h0)
    else $error("flag read data wrong");
  update_flag_a: assert property (
    s_update_done |=> flags_q.update_done_flag)
    else $error("update flag not set");
  spring_jump_a: assert property (
    s_spring_step |=> time_q.hour == DST_SPRING_HOUR
      && time_q.min == 6'h00 && time_q.sec == 6'h00)
    else $error("spring adjustment wrong");
  no_tap_a: assert property (
    rate_q == 4'h0 && !flags_q.periodic_flag |=> !flags_q.periodic_flag)
    else $error("periodic flag set with no tap");
  one_per_sec_a: assert property (
    sec_tick && !cfg_q.update_inhibit && state_q == ST_IDLE
    |=> state_q == ST_INC)
    else $error("update did not start on second");
endmodule

// ### test/rtc_control_and_flags_tb.sv
// Self-checking bench for the RTC configuration and event flag logic
`timescale 1ns/1ps
module rtc_control_and_flags_tb;
  import rtcc_pkg::*;
  // ==========================================================
  // Clock, reset and design ports
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic resume_well_reset_n_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic clock_interrupt_n_out;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int cfg_m = 0; // Model of the configuration byte
  logic [7:0] rd_v;
  int i;
  always #12.5 sys_clk_in = ~sys_clk_in;
  // Tick of one clock so one second is 32768 clocks
  rtcc_core #(.TICK_CYCLES(1)) rtcc_core_inst (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .resume_well_reset_n_in(resume_well_reset_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .clock_interrupt_n_out(clock_interrupt_n_out)
  );
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      $display("BAD t=%0t run too long", $time);
      end_sim();
    end
  end
  // Expected flag byte with the combined request bit on top
  function automatic logic [7:0] flags_exp(bit p, bit a, bit u, int c);
    bit irq;
    irq = (p & c[6]) | (a & c[5]) | (u & c[4]);
    return {irq, p, a, u, 4'h0};
  endfunction
  // ==========================================================
  // Register port master
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    if (a == OFF_CONFIG) begin
      cfg_m = d;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(63));
    repeat (8) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    // Reset values, unmapped place and idle interrupt pin
    rd(OFF_CONFIG, rd_v);
    chk(rd_v, 8'h00, "config reset");
    rd(OFF_FLAGS, rd_v);
    chk(rd_v, 8'h00, "flags reset");
    rd(8'h0D, rd_v);
    chk(rd_v, 8'h00, "unmapped read");
    chk(8'(clock_interrupt_n_out), 8'h01, "pin idle");
    $display("test reset done");
    // Random configuration, flag write ignored, resume-well reset
    for (i = 0; i < 4; i++) begin
      wr(OFF_CONFIG, 8'($urandom) & 8'h8F);
      wr(OFF_FLAGS, 8'hFF);
      rd(OFF_CONFIG, rd_v);
      chk(rd_v, 8'(cfg_m), "config readback");
      rd(OFF_FLAGS, rd_v);
      chk(rd_v, 8'h00, "flags not writable");
    end
    wr(OFF_CONFIG, 8'($urandom) | 8'h78);
    @(posedge sys_clk_in);
    resume_well_reset_n_in <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
    resume_well_reset_n_in <= 1'b1;
    cfg_m = cfg_m & 8'h87;
    repeat (10) @(posedge sys_clk_in);
    rd(OFF_CONFIG, rd_v);
    chk(rd_v, 8'(cfg_m), "resume reset keeps");
    rd(OFF_FLAGS, rd_v);
    chk(rd_v, 8'h00, "resume reset flags");
    $display("test resume reset done");
    // Periodic flag, enabled and then gated off, then rate zero
    wr(OFF_CONFIG, 8'h40);
    wr(OFF_RATE, 8'h03);
    repeat (20) @(posedge sys_clk_in);
    #1;
    chk(8'(clock_interrupt_n_out), 8'h00, "periodic pin");
    rd(OFF_FLAGS, rd_v);
    chk(rd_v, flags_exp(1'b1, 1'b0, 1'b0, cfg_m), "periodic on");
    wr(OFF_CONFIG, 8'h00);
    repeat (20) @(posedge sys_clk_in);
    rd(OFF_FLAGS, rd_v);
    chk(rd_v, flags_exp(1'b1, 1'b0, 1'b0, cfg_m), "periodic gated");
    chk(8'(clock_interrupt_n_out), 8'h01, "gated pin");
    wr(OFF_RATE, 8'h00);
    rd(OFF_FLAGS, rd_v);
    repeat (20) @(posedge sys_clk_in);
    rd(OFF_FLAGS, rd_v);
    chk(rd_v, 8'h00, "rate zero");
    $display("test periodic done");
    // Alarm match after one update, flags cleared by the read
    wr(OFF_CONFIG, 8'h80);
    wr(OFF_SEC, 8'h05);
    wr(OFF_MIN, 8'h00);
    wr(OFF_HOUR, 8'h00);
    wr(OFF_ALM_SEC, 8'h06);
    wr(OFF_ALM_MIN, 8'h00);
    wr(OFF_ALM_HOUR, 8'h00);
    // Saving off and time far from any saving point
    wr(OFF_CONFIG, 8'h30);
    i = 0;
    while (clock_interrupt_n_out !== 1'b0 && i < 34000) begin
      @(posedge sys_clk_in);
      #1;
      i++;
    end
    chk(8'(clock_interrupt_n_out), 8'h00, "update pin");
    rd(OFF_FLAGS, rd_v);
    chk(rd_v, flags_exp(1'b0, 1'b1, 1'b1, cfg_m),
        "alarm flags");
    chk(8'(clock_interrupt_n_out), 8'h01, "read clears");
    rd(OFF_SEC, rd_v);
    chk(rd_v, 8'h06, "one second step");
    $display("test alarm done");
    // Inhibited updates: no flag and no time step for over a second
    wr(OFF_CONFIG, 8'h90);
    i = 0;
    repeat (33500) begin
      @(posedge sys_clk_in);
      #1;
      if (clock_interrupt_n_out === 1'b0) begin
        i++;
      end
    end
    chk(8'(i != 0), 8'h00, "inhibit pin");
    rd(OFF_FLAGS, rd_v);
    chk(rd_v, 8'h00, "inhibit flags");
    rd(OFF_SEC, rd_v);
    chk(rd_v, 8'h06, "inhibit time");
    $display("test inhibit done");
    // Binary 24 hour and BCD 12 hour views of one stored time
    wr(OFF_CONFIG, 8'h86);
    wr(OFF_HOUR, 8'h17);
    wr(OFF_SEC, 8'h2A);
    rd(OFF_HOUR, rd_v);
    chk(rd_v, 8'h17, "binary 24h hour");
    rd(OFF_SEC, rd_v);
    chk(rd_v, 8'h2A, "binary sec");
    wr(OFF_CONFIG, 8'h80);
    rd(OFF_HOUR, rd_v);
    chk(rd_v, 8'h91, "12h pm hour");
    rd(OFF_SEC, rd_v);
    chk(rd_v, 8'h42, "bcd sec");
    wr(OFF_HOUR, 8'h12);
    wr(OFF_CONFIG, 8'h86);
    rd(OFF_HOUR, rd_v);
    chk(rd_v, 8'h00, "12 am is hour zero");
    $display("test modes done");
    end_sim();
  end
endmodule
